// >>> include/rap_pkg.sv
// Types shared by the RS-485 addressed serial port
`default_nettype none
package rap_pkg;
  typedef enum logic [1:0] {RAP_PAR_NONE, RAP_PAR_ODD, RAP_PAR_EVEN} rap_par_e;
  typedef enum logic [2:0] {RAP_P_IDLE, RAP_P_D1, RAP_P_D2, RAP_P_TERM, RAP_P_DATA} rap_parse_e;
endpackage
`default_nettype wire

// >>> include/rap_regs.svh
// Register map, field positions, reset values and line constants of the RS-485 port
`ifndef RAP_REGS_SVH
`define RAP_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RAP_OFS_CTRL 5'h00
`define RAP_OFS_ID 5'h04
`define RAP_OFS_STAT 5'h08
`define RAP_OFS_TXD 5'h0C
`define RAP_OFS_RXD 5'h10

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define RAP_CTRL_BAUD_LSB 0
`define RAP_CTRL_LEN8 3
`define RAP_CTRL_STOP2 4
`define RAP_CTRL_PAR_LSB 5
`define RAP_CTRL_CRLF 7
`define RAP_CTRL_RST 8'h0B
`define RAP_ID_RST 7'h00

// ----------------------------------------
// Status bits
// ----------------------------------------
`define RAP_ST_OPEN 0
`define RAP_ST_RXV 1
`define RAP_ST_PERR 2
`define RAP_ST_TXBUSY 3
`define RAP_ST_TXREF 4
`define RAP_ST_OVR 5
`define RAP_ST_FERR 6

// ----------------------------------------
// Line rates in bit/s and characters
// ----------------------------------------
`define RAP_BAUD_0 1200
`define RAP_BAUD_1 2400
`define RAP_BAUD_2 4800
`define RAP_BAUD_3 9600
`define RAP_BAUD_4 19200
`define RAP_CH_START 8'h53
`define RAP_CH_END 8'h45
`define RAP_CH_CR 8'h0D
`define RAP_CH_LF 8'h0A
`define RAP_CH_ZERO 8'h30
`define RAP_CH_NINE 8'h39

`endif

// >>> logic/rap_serial_port.sv
// RS-485 addressed serial port: UART, ID open/close, driver control, Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "rap_regs.svh"

module rap_serial_port #(
  parameter int CLK_HZ = 40_000_000
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxd,
  output logic txd,
  output logic tx_oe
);

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  localparam logic [16:0] DIV_TAB [5] = '{17'(CLK_HZ / `RAP_BAUD_0), 17'(CLK_HZ / `RAP_BAUD_1),
    17'(CLK_HZ / `RAP_BAUD_2), 17'(CLK_HZ / `RAP_BAUD_3), 17'(CLK_HZ / `RAP_BAUD_4)};

  if (CLK_HZ / `RAP_BAUD_4 < 4 || CLK_HZ / `RAP_BAUD_0 > 131071) begin : g_chk
    $error("CLK_HZ outside the range the bit timers serve");
  end

  logic [7:0] ctrl_q;
  logic [6:0] id_q;
  logic [2:0] baud_sel;
  logic len8, stop2, crlf;
  rap_pkg::rap_par_e par;
  logic [16:0] bit_div;
  assign baud_sel = ctrl_q[`RAP_CTRL_BAUD_LSB +: 3];
  assign len8 = ctrl_q[`RAP_CTRL_LEN8];
  assign stop2 = ctrl_q[`RAP_CTRL_STOP2];
  assign crlf = ctrl_q[`RAP_CTRL_CRLF];
  assign par = rap_pkg::rap_par_e'(ctrl_q[`RAP_CTRL_PAR_LSB +: 2]);
  // Unused rate codes fall back to 9600
  assign bit_div = (baud_sel > 3'h4) ? DIV_TAB[3] : DIV_TAB[baud_sel];

  logic par_on;
  logic [3:0] data_bits;
  assign par_on = (par == rap_pkg::RAP_PAR_ODD) || (par == rap_pkg::RAP_PAR_EVEN);
  assign data_bits = len8 ? 4'h8 : 4'h7;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic rd_ack_q, open, open_q;
  logic tx_busy_q, rep_act_q, close_pend_q;
  logic sel_ctrl, sel_id, sel_stat, sel_txd, sel_rxd, wr0;
  logic sw_tx, tx_wait, sw_load, sw_refuse, rd_take;
  assign sel_ctrl = (avs_address == `RAP_OFS_CTRL);
  assign sel_id = (avs_address == `RAP_OFS_ID);
  assign sel_stat = (avs_address == `RAP_OFS_STAT);
  assign sel_txd = (avs_address == `RAP_OFS_TXD);
  assign sel_rxd = (avs_address == `RAP_OFS_RXD);
  assign wr0 = avs_write && avs_byteenable[0];
  assign sw_tx = wr0 && sel_txd;
  // Writes to the transmit data register stall while the line is busy
  assign tx_wait = sw_tx && open && (tx_busy_q || rep_act_q);
  assign sw_load = sw_tx && open && !tx_busy_q && !rep_act_q;
  assign sw_refuse = sw_tx && !open;
  assign avs_waitrequest = (avs_read && !rd_ack_q) || tx_wait;
  assign rd_take = avs_read && rd_ack_q;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [7:0] tx_byte, rep_byte, tx_dm;
  logic tx_go, tx_pbit, txd_q;
  logic [11:0] tx_frame, tx_sh_q;
  logic [3:0] tx_nbits, tx_n_q;
  logic [16:0] tx_cnt_q;
  assign tx_go = (rep_act_q && !tx_busy_q) || sw_load;
  assign tx_byte = rep_act_q ? rep_byte : avs_writedata[7:0];
  assign tx_dm = len8 ? tx_byte : {1'h0, tx_byte[6:0]};
  assign tx_pbit = (^tx_dm) ^ (par == rap_pkg::RAP_PAR_ODD);
  // Padding above the frame is all ones, so the stop bits need no extra logic
  assign tx_frame = len8 ? (par_on ? {2'h3, tx_pbit, tx_dm, 1'h0} : {3'h7, tx_dm, 1'h0})
                         : (par_on ? {3'h7, tx_pbit, tx_dm[6:0], 1'h0} : {4'hF, tx_dm[6:0], 1'h0});
  assign tx_nbits = 4'h1 + data_bits + {3'h0, par_on} + (stop2 ? 4'h2 : 4'h1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_busy_q <= 1'h0;
      txd_q <= 1'h1;
      tx_sh_q <= 12'hFFF;
      tx_n_q <= 4'h0;
      tx_cnt_q <= 17'h0_0000;
    end else if (tx_go) begin
      tx_busy_q <= 1'h1;
      txd_q <= tx_frame[0];
      tx_sh_q <= {1'h1, tx_frame[11:1]};
      tx_n_q <= tx_nbits - 4'h1;
      tx_cnt_q <= bit_div - 17'h0_0001;
    end else if (tx_busy_q && tx_cnt_q != 17'h0_0000) begin
      tx_cnt_q <= tx_cnt_q - 17'h0_0001;
    end else if (tx_busy_q) begin
      tx_cnt_q <= bit_div - 17'h0_0001;
      tx_n_q <= tx_n_q - 4'h1;
      txd_q <= (tx_n_q == 4'h0) ? 1'h1 : tx_sh_q[0];
      tx_sh_q <= {1'h1, tx_sh_q[11:1]};
      tx_busy_q <= (tx_n_q != 4'h0);
    end
  end

  assign txd = txd_q;
  // Driver only while a frame of our own is on the wire
  assign tx_oe = tx_busy_q && open;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic rx_busy_q, rx_done_q, rx_perr, rx_ferr;
  logic [3:0] rx_idx_q, rx_last;
  logic [16:0] rx_cnt_q;
  logic [11:0] rx_bits_q;
  logic [7:0] rx_ch;
  assign rx_last = 4'h1 + data_bits + {3'h0, par_on};
  assign rx_ch = len8 ? rx_bits_q[8:1] : {1'h0, rx_bits_q[7:1]};
  assign rx_perr = par_on && ((^rx_ch) ^ (len8 ? rx_bits_q[9] : rx_bits_q[8])
                   ^ (par == rap_pkg::RAP_PAR_ODD));
  assign rx_ferr = !rx_bits_q[rx_last];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_busy_q <= 1'h0;
      rx_done_q <= 1'h0;
      rx_idx_q <= 4'h0;
      rx_cnt_q <= 17'h0_0000;
      rx_bits_q <= 12'h000;
    end else begin
      rx_done_q <= 1'h0;
      if (!rx_busy_q) begin
        if (!rxd) begin
          rx_busy_q <= 1'h1;
          rx_idx_q <= 4'h0;
          rx_cnt_q <= {1'h0, bit_div[16:1]}; // Sample at mid bit
        end
      end else if (rx_cnt_q != 17'h0_0000) begin
        rx_cnt_q <= rx_cnt_q - 17'h0_0001;
      end else begin
        rx_cnt_q <= bit_div - 17'h0_0001;
        rx_bits_q[rx_idx_q] <= rxd;
        rx_idx_q <= rx_idx_q + 4'h1;
        // A start bit that is gone at mid bit was a glitch
        if ((rx_idx_q == 4'h0 && rxd) || rx_idx_q == rx_last) begin
          rx_busy_q <= 1'h0;
          rx_done_q <= (rx_idx_q == rx_last);
        end
      end
    end
  end

  // ----------------------------------------
  // Message parser, ID match and reply
  // ----------------------------------------
  rap_pkg::rap_parse_e pst_q;
  logic [7:0] cmd_q, d1_q, d2_q;
  logic is_digit, is_cmd, cmd_eval, cmd_hit, fwd, rep_last;
  logic [2:0] rep_idx_q;
  logic [6:0] cmd_id;
  assign is_digit = (rx_ch >= `RAP_CH_ZERO) && (rx_ch <= `RAP_CH_NINE);
  assign is_cmd = (rx_ch == `RAP_CH_START) || (rx_ch == `RAP_CH_END);
  assign cmd_id = 7'(({3'h0, d1_q[3:0]} * 7'h0A) + {3'h0, d2_q[3:0]});
  assign cmd_eval = rx_done_q && (pst_q == rap_pkg::RAP_P_TERM) && (rx_ch == `RAP_CH_CR);
  assign cmd_hit = cmd_eval && (cmd_id == id_q);
  // Data reaches software only while open; otherwise dropped
  assign fwd = rx_done_q && open && !(pst_q == rap_pkg::RAP_P_IDLE && (is_cmd || rx_ch == `RAP_CH_LF))
               && (pst_q == rap_pkg::RAP_P_IDLE || pst_q == rap_pkg::RAP_P_DATA);
  assign open = open_q || (id_q == 7'h00);
  assign rep_last = (rep_idx_q == (crlf ? 3'h4 : 3'h3));
  assign rep_byte = (rep_idx_q == 3'h0) ? cmd_q : (rep_idx_q == 3'h1) ? d1_q :
                    (rep_idx_q == 3'h2) ? d2_q : (rep_idx_q == 3'h3) ? `RAP_CH_CR : `RAP_CH_LF;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pst_q <= rap_pkg::RAP_P_IDLE;
      cmd_q <= 8'h00;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
    end else if (rx_done_q) begin
      case (pst_q)
        rap_pkg::RAP_P_IDLE: begin
          if (is_cmd) begin
            cmd_q <= rx_ch;
            pst_q <= rap_pkg::RAP_P_D1;
          end else if (rx_ch != `RAP_CH_LF && rx_ch != `RAP_CH_CR) begin
            pst_q <= rap_pkg::RAP_P_DATA;
          end
        end
        rap_pkg::RAP_P_D1: begin
          d1_q <= rx_ch;
          pst_q <= is_digit ? rap_pkg::RAP_P_D2 : rap_pkg::RAP_P_IDLE;
        end
        rap_pkg::RAP_P_D2: begin
          d2_q <= rx_ch;
          pst_q <= is_digit ? rap_pkg::RAP_P_TERM : rap_pkg::RAP_P_IDLE;
        end
        rap_pkg::RAP_P_TERM: pst_q <= rap_pkg::RAP_P_IDLE;
        default: begin
          if (rx_ch == `RAP_CH_CR) begin
            pst_q <= rap_pkg::RAP_P_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      open_q <= 1'h0;
      rep_act_q <= 1'h0;
      rep_idx_q <= 3'h0;
      close_pend_q <= 1'h0;
    end else begin
      if (cmd_hit && !rep_act_q) begin
        rep_act_q <= 1'h1;
        rep_idx_q <= 3'h0;
        if (cmd_q == `RAP_CH_START) begin
          open_q <= 1'h1;
        end else begin
          close_pend_q <= 1'h1;
        end
      end else if (rep_act_q && !tx_busy_q) begin
        rep_idx_q <= rep_idx_q + 3'h1;
        rep_act_q <= !rep_last;
      end else if (close_pend_q && !rep_act_q && !tx_busy_q) begin
        // Close only after the end reply has left the line
        open_q <= 1'h0;
        close_pend_q <= 1'h0;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic rxv_q, perr_q, txref_q, ovr_q, ferr_q;
  logic [7:0] rxd_q;
  logic stat_clr, rx_clr;
  logic [31:0] rd_mux;
  assign stat_clr = wr0 && sel_stat;
  assign rx_clr = rd_take && sel_rxd;
  assign rd_mux = sel_ctrl ? {24'h00_0000, ctrl_q} :
                  sel_id ? {25'h000_0000, id_q} :
                  sel_stat ? {25'h000_0000, ferr_q, ovr_q, txref_q, tx_busy_q, perr_q, rxv_q, open} :
                  sel_rxd ? {24'h00_0000, rxd_q} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `RAP_CTRL_RST;
      id_q <= `RAP_ID_RST;
      rd_ack_q <= 1'h0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack_q <= avs_read && !rd_ack_q;
      if (avs_read && !rd_ack_q) begin
        avs_readdata <= rd_mux;
      end
      if (wr0 && sel_ctrl) begin
        ctrl_q <= avs_writedata[7:0];
      end
      if (wr0 && sel_id) begin
        id_q <= avs_writedata[6:0];
      end
    end
  end

  // Sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxv_q <= 1'h0;
      rxd_q <= 8'h00;
      perr_q <= 1'h0;
      txref_q <= 1'h0;
      ovr_q <= 1'h0;
      ferr_q <= 1'h0;
    end else begin
      rxv_q <= fwd || (rxv_q && !rx_clr);
      if (fwd) begin
        rxd_q <= rx_ch;
      end
      perr_q <= (rx_done_q && rx_perr) || (perr_q && !(stat_clr && avs_writedata[`RAP_ST_PERR]));
      ferr_q <= (rx_done_q && rx_ferr) || (ferr_q && !(stat_clr && avs_writedata[`RAP_ST_FERR]));
      txref_q <= sw_refuse || (txref_q && !(stat_clr && avs_writedata[`RAP_ST_TXREF]));
      ovr_q <= (fwd && rxv_q && !rx_clr) || (ovr_q && !(stat_clr && avs_writedata[`RAP_ST_OVR]));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_oe_closed: assert property (@(posedge clk_sys) disable iff (!nrst) !open |-> !tx_oe)
    else $error("driver enabled while closed");
  a_oe_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tx_busy_q && tx_n_q == 4'h0 && tx_cnt_q == 17'h0_0000) |=> !tx_oe && txd)
    else $error("driver not released after last stop bit");
  a_zero_open: assert property (@(posedge clk_sys) disable iff (!nrst) (id_q == 7'h00) |-> open)
    else $error("ID zero unit not open");
  a_start_opens: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cmd_hit && !rep_act_q && cmd_q == `RAP_CH_START) |=> open_q ##1 rep_act_q)
    else $error("matching start did not open");
  a_reply_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(rep_act_q) |-> $past(cmd_hit) && $past(cmd_id) == $past(id_q))
    else $error("reply without matching ID");
  a_closed_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rx_done_q && !open) |=> !$rose(rxv_q))
    else $error("message accepted while closed");
  a_start_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tx_go && !tx_busy_q) |=> !txd && tx_busy_q)
    else $error("frame did not open with start bit");
  a_bit_time: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tx_busy_q && $past(tx_busy_q) && $changed(txd)) |-> $past(tx_cnt_q) == 17'h0_0000)
    else $error("line changed inside a bit");
  a_stop_high: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tx_busy_q && tx_n_q < (stop2 ? 4'h2 : 4'h1)) |-> txd)
    else $error("stop bit not high");
  a_parity_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(perr_q) |-> $past(par_on))
    else $error("parity error with parity off");
  a_reply_term: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rep_act_q && !tx_busy_q && rep_last) |-> (tx_byte == (crlf ? `RAP_CH_LF : `RAP_CH_CR)))
    else $error("reply not terminated as configured");

endmodule
`default_nettype wire

// >>> tb/rap_host_model.sv
// Host-side model of the RS-485 bus master: frames characters out, captures replies
`timescale 1ns/1ps
`default_nettype none
module rap_host_model (
  input wire logic clk_sys,
  input wire logic txd,
  input wire logic tx_oe,
  output logic rxd
);
  // ----------------------------------------
  // Line settings, set by the bench
  // ----------------------------------------
  int bit_cyc = 40;
  int nbits = 8;
  bit stop2 = 1'b0;
  int par = 0;
  bit crlf = 1'b0;
  logic [8:0] rx_q[$];
  logic [7:0] sh;
  logic bad;
  logic line_lvl;
  // Idle line held high, as a fail-safe biased pair would be
  initial rxd = 1'b1;
  // A released driver leaves the pair at its fail-safe high level
  assign line_lvl = (tx_oe === 1'b1) ? txd : 1'b1;

  function automatic logic par_of(input logic [7:0] c, input int n, input int m);
    logic x;
    x = (n == 7) ? ^c[6:0] : ^c;
    return (m == 1) ? ~x : x;
  endfunction

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  task automatic send_char(input logic [7:0] c, input bit bad_par);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      rxd <= c[i];
      repeat (bit_cyc) @(posedge clk_sys);
    end
    if (par != 0) begin
      rxd <= par_of(c, nbits, par) ^ bad_par;
      repeat (bit_cyc) @(posedge clk_sys);
    end
    rxd <= 1'b1;
    repeat (stop2 ? 2 * bit_cyc : bit_cyc) @(posedge clk_sys);
  endtask

  // ASCII text, then the configured terminator
  task automatic send_msg(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_char(s[i], 1'b0);
    end
    send_char(8'h0D, 1'b0);
    if (crlf) begin
      send_char(8'h0A, 1'b0);
    end
  endtask

  // ----------------------------------------
  // Receive side; bit 8 flags a bad parity or stop bit
  // ----------------------------------------
  initial begin
    forever begin
      @(posedge clk_sys);
      if (line_lvl === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge clk_sys);
        sh = 8'h00;
        for (int i = 0; i < nbits; i++) begin
          repeat (bit_cyc) @(posedge clk_sys);
          sh[i] = line_lvl;
        end
        bad = 1'b0;
        if (par != 0) begin
          repeat (bit_cyc) @(posedge clk_sys);
          bad = (line_lvl !== par_of(sh, nbits, par));
        end
        repeat (bit_cyc) @(posedge clk_sys);
        bad = bad | (line_lvl !== 1'b1);
        rx_q.push_back({bad, sh});
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/rs485_addressed_serial_port_tb_top.sv
// Self-checking bench for the RS-485 addressed serial port
`timescale 1ns/1ps
`default_nettype none
`include "rap_regs.svh"
module rs485_addressed_serial_port_tb_top;
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, rxd, txd, tx_oe;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  int n_mismatch = 0;
  int samples_checked = 0;
  int rates[5] = '{`RAP_BAUD_0, `RAP_BAUD_1, `RAP_BAUD_2, `RAP_BAUD_3, `RAP_BAUD_4};
  logic [7:0] cfgs[5] = '{8'h08, 8'h31, 8'h4A, 8'h43, 8'h3C};

  // Small clock figure keeps the 10-bit 1200 bit/s frame near 3200 cycles
  rap_serial_port #(.CLK_HZ(384000)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxd(rxd), .txd(txd), .tx_oe(tx_oe));
  rap_host_model host_u (.clk_sys(clk_sys), .txd(txd), .tx_oe(tx_oe), .rxd(rxd));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20000);
    if (avs_waitrequest !== 1'b0) begin
      chk("bus wait bound", 32'h0000_0001, 32'h0000_0000);
      conclude();
    end
  endtask

  task automatic av_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    rd = 32'h0000_0000;
    avs_write <= 1'b0;
  endtask

  task automatic av_read(input logic [4:0] a);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 60000 && host_u.rx_q.size() < n; k++) begin
      @(posedge clk_sys);
    end
    if (host_u.rx_q.size() < n) begin
      chk("reply count", host_u.rx_q.size(), n);
      conclude();
    end
  endtask

  // Echo of a command: letter, two digits, CR, LF
  task automatic chk_echo(input string s);
    wait_rx(5);
    for (int i = 0; i < 3; i++) begin
      chk("echo char", host_u.rx_q.pop_front(), {24'h0, s[i]});
    end
    chk("echo cr", host_u.rx_q.pop_front(), 32'h0000_000D);
    chk("echo lf", host_u.rx_q.pop_front(), 32'h0000_000A);
    repeat (host_u.bit_cyc + 2) @(posedge clk_sys);
    chk("driver after reply", tx_oe, 1'b0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    av_read(`RAP_OFS_CTRL);
    chk("ctrl reset", rd, 32'h0000_000B);
    av_read(`RAP_OFS_ID);
    chk("id reset", rd, 32'h0000_0000);
    av_read(`RAP_OFS_STAT);
    chk("open at power-up", rd[0], 1'b1);
    av_read(5'h14);
    chk("unmapped read", rd, 32'h0000_0000);
    avs_byteenable <= 4'hE;
    av_write(`RAP_OFS_CTRL, 32'h0000_00FF);
    avs_byteenable <= 4'hF;
    av_read(`RAP_OFS_CTRL);
    chk("lane 0 off", rd, 32'h0000_000B);
    chk("idle driver", tx_oe, 1'b0);
    $display("test reset done");
  endtask

  // Every rate, both lengths, both stop counts, every parity, both directions
  task automatic t_formats;
    logic [7:0] c;
    for (int k = 0; k < 5; k++) begin
      c = cfgs[k];
      host_u.bit_cyc = 384000 / rates[c[2:0]];
      host_u.nbits = c[3] ? 8 : 7;
      host_u.stop2 = c[4];
      host_u.par = c[6:5];
      av_write(`RAP_OFS_CTRL, {24'h0, c});
      av_write(`RAP_OFS_TXD, 32'h0000_00C3);
      repeat (host_u.bit_cyc / 2) @(posedge clk_sys);
      chk("start bit", {tx_oe, txd}, 2'b10);
      wait_rx(1);
      chk("tx frame", host_u.rx_q.pop_front(), c[3] ? 32'h0000_00C3 : 32'h0000_0043);
      repeat ((c[4] ? 2 : 1) * host_u.bit_cyc) @(posedge clk_sys);
      chk("driver after frame", tx_oe, 1'b0);
      host_u.send_char(8'h5A, 1'b0);
      av_read(`RAP_OFS_RXD);
      chk("rx char", rd, 32'h0000_005A);
      av_read(`RAP_OFS_STAT);
      chk("rx flags", rd[6:5], 2'b00);
      chk("rx parity", rd[2], 1'b0);
      host_u.send_char(8'h0D, 1'b0);
      av_read(`RAP_OFS_RXD);
      chk("rx cr", rd, 32'h0000_000D);
    end
    host_u.send_char(8'h5A, 1'b1);
    av_read(`RAP_OFS_STAT);
    chk("parity error", rd[2], 1'b1);
    av_write(`RAP_OFS_STAT, 32'h0000_0004);
    av_read(`RAP_OFS_STAT);
    chk("parity cleared", rd[2], 1'b0);
    host_u.send_char(8'h0D, 1'b0);
    av_read(`RAP_OFS_RXD);
    chk("rx last cr", rd, 32'h0000_000D);
    av_read(`RAP_OFS_STAT);
    chk("overrun", rd[5], 1'b1);
    chk("rx valid cleared", rd[1], 1'b0);
    $display("test formats done");
  endtask

  // Unit 12 on a shared line: closed, wrong ID, open, data, close
  task automatic t_address;
    host_u.bit_cyc = 40;
    host_u.nbits = 8;
    host_u.stop2 = 1'b0;
    host_u.par = 0;
    host_u.crlf = 1'b1;
    av_write(`RAP_OFS_CTRL, 32'h0000_008B);
    av_write(`RAP_OFS_ID, 32'h0000_000C);
    av_read(`RAP_OFS_STAT);
    chk("closed", rd[0], 1'b0);
    av_write(`RAP_OFS_TXD, 32'h0000_0041);
    repeat (80) @(posedge clk_sys);
    chk("driver held off", tx_oe, 1'b0);
    av_read(`RAP_OFS_STAT);
    chk("tx refused", rd[4], 1'b1);
    av_write(`RAP_OFS_STAT, 32'h0000_0010);
    host_u.send_msg("R1");
    av_read(`RAP_OFS_STAT);
    chk("ignored while closed", rd[1], 1'b0);
    host_u.send_msg("S13");
    repeat (400) @(posedge clk_sys);
    chk("no reply to other id", host_u.rx_q.size(), 0);
    host_u.send_msg("S12");
    chk_echo("S12");
    av_read(`RAP_OFS_STAT);
    chk("opened", rd[0], 1'b1);
    host_u.send_char(8'h51, 1'b0);
    av_read(`RAP_OFS_RXD);
    chk("data while open", rd, 32'h0000_0051);
    av_write(`RAP_OFS_TXD, 32'h0000_0031);
    av_write(`RAP_OFS_TXD, 32'h0000_0032);
    wait_rx(2);
    chk("first queued", host_u.rx_q.pop_front(), 32'h0000_0031);
    chk("stalled write", host_u.rx_q.pop_front(), 32'h0000_0032);
    repeat (host_u.bit_cyc + 2) @(posedge clk_sys);
    chk("driver after pair", tx_oe, 1'b0);
    host_u.send_msg("");
    host_u.send_msg("E12");
    chk_echo("E12");
    av_read(`RAP_OFS_STAT);
    chk("closed again", rd[0], 1'b0);
    av_write(`RAP_OFS_TXD, 32'h0000_0041);
    repeat (80) @(posedge clk_sys);
    chk("driver off after end", tx_oe, 1'b0);
    av_read(`RAP_OFS_STAT);
    chk("refused after end", rd[4], 1'b1);
    $display("test addressing done");
  endtask

  initial begin
    nrst = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_formats();
    t_address();
    conclude();
  end
endmodule
`default_nettype wire
